/* rtl/ssc_pkg.sv */
// Purpose: shared constants and types for the serial status and clock select block
// Assumes: 32-bit classic wishbone, registers one aligned word each
// Notes:   field positions and reset values live here only
package ssc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS  = 8'h00; // serial_status_flags
    localparam logic [7:0] OFF_CONTROL = 8'h04; // serial_control_flags
    localparam logic [7:0] OFF_MODE    = 8'h08; // serial_mode_reg (sync bit only)
    localparam logic [7:0] OFF_RXDATA  = 8'h0C; // rx_data_reg, read only

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int BIT_TX_HOLDING_EMPTY = 7; // tx_holding_empty
    localparam int BIT_RX_HOLDING_FULL = 6; // rx_holding_full
    localparam int BIT_OVERRUN_FLAG = 5; // overrun_flag
    localparam int BIT_FER  = 4; // framing_fault
    localparam int BIT_PER  = 3; // parity_fault
    localparam int BIT_TX_DONE = 2; // tx_done
    localparam int BIT_MPB  = 1; // rx_multiproc_bit
    localparam int BIT_MPBT = 0; // transmit multiprocessor bit, plain rw

    // control and mode field positions
    localparam int BIT_TXON = 5; // tx_on
    localparam int BIT_RXON = 4; // rx_on
    localparam int BIT_TX_DONE_IRQ_EN = 2; // tx_done_irq_en
    localparam int BIT_CKH  = 1; // clk_src_sel_hi
    localparam int BIT_CKL  = 0; // clk_src_sel_lo
    localparam int BIT_SYNC = 7; // mode: 1 = synchronous

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STATUS  = 8'h84;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE    = 8'h00;

    // receive event carried from the receiver into this block
    typedef struct packed {
        logic       done;      // character complete, one cycle
        logic       stop_bit;  // first stop bit as sampled
        logic       par_err;   // parity mismatch
        logic       rx_multiproc_bit;       // received multiprocessor bit
        logic [7:0] data;      // received character
    } ssc_rx_evt_t;

    // sck pin drive as two signals
    typedef struct packed {
        logic out;  // level driven
        logic oe;   // high while driving
    } ssc_pin_drv_t;
endpackage : ssc_pkg

/* rtl/ssc_top.sv */
// Purpose: status flags, read-then-clear protocol and clock source select
// Assumes: receiver/transmitter datapath sits outside and reports events
// Notes:   sck pin sampled by core_clk_in through two flops before use
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// one software-clearable flag with read-then-write-0 protocol
// ------------------------------------------------------------
module ssc_rc_flag #(
    parameter logic RST_VAL = 1'b0 // value after reset and standby
) (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic init_in,  // standby entry, same as reset
    input  wire logic set_in,   // hardware set
    input  wire logic hw_clr_in,// hardware clear, e.g. dma read
    input  wire logic rd_in,    // status read accepted
    input  wire logic wr_in,    // status write accepted
    input  wire logic wdat_in,  // written bit value
    output logic      flag_out  // current flag
);
    logic seen_q; // flag was read while at 1

    // flag itself: init first, then set wins over any clear
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= RST_VAL;
        end else if (init_in) begin
            flag_out <= RST_VAL;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (hw_clr_in) begin
            flag_out <= 1'b0;
        end else if (wr_in && !wdat_in && seen_q) begin
            flag_out <= 1'b0;
        end
    end

    // arm the clear only by reading the flag at 1
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_q <= 1'b0;
        end else if (init_in || wr_in) begin
            seen_q <= 1'b0;
        end else if (rd_in && flag_out) begin
            seen_q <= 1'b1;
        end
    end
endmodule // ssc_rc_flag

// Functional notes
// - transmit-end request gated by tx_done_irq_en
// - request drops on tx_holding_empty clear or enable off
// - clk_src_sel_lo only counts async internal
// - sel 00: internal; async pin free, sync drives
// - sel 01: internal clock driven on pin
// - sel 1x: pin is clock input
// - write 1 ignored; 0 clears after read-1
// - tx_done and rx_multiproc_bit are read only
// - status loads 0x84 on reset/standby
// - tx_holding_empty set on init, tx off, shift load
// - tx_holding_empty clears only by read-1 then write-0
// - rx_holding_full set on clean receive transfer
// - rx_holding_full cleared by init, sw, dma read
// - errors keep rx_holding_full; only overrun, halt and rx off keep data
// - overrun sets flag, keeps old character
// - overrun halts rx; sync also halts tx
// - overrun cleared by init or sw only
// - async stop bit 0 sets framing_fault
// - framing_fault cleared by init or sw only
// - framing error loads data, rx_holding_full stays
// - tx_done set when tx_holding_empty high at end
module ssc_top #(
    parameter int ADDR_W   = 8, // wishbone byte address width
    parameter int BAUD_DIV = 8  // core cycles per half bit-rate clock
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_n_in,
    // wishbone classic slave
    input  wire logic                 wb_cyc_in,
    input  wire logic                 wb_stb_in,
    input  wire logic                 wb_we_in,
    input  wire logic [ADDR_W-1:0]    wb_adr_in,
    input  wire logic [3:0]           wb_sel_in,
    input  wire logic [31:0]          wb_dat_in,
    output logic [31:0]               wb_dat_out,
    output logic                      wb_ack_out,
    // events from the serial datapath, same clock
    input  wire logic                 standby_in,      // standby entry
    input  wire ssc_pkg::ssc_rx_evt_t rx_evt_in,       // receive completion
    input  wire logic                 tx_load_in,      // tx_data_reg moved to shift
    input  wire logic                 tx_last_bit_in,  // last bit shifted out
    input  wire logic                 dma_rd_in,       // dma_unit reads rx data
    // serial clock pin
    input  wire logic                 sck_pin_in,
    output logic                      sck_pin_out,
    output logic                      sck_pin_oe_out,
    // to the datapath
    output logic                      bit_clk_tick_out, // serial clock edge
    output logic                      ext_clk_sel_out,  // pin is clock source
    output logic                      rx_halt_out,      // reception stopped
    output logic                      tx_halt_out,      // transmission stopped
    output logic                      tx_on_out,
    output logic                      rx_on_out,
    output logic [7:0]                rx_data_out,      // rx_data_reg contents
    output logic                      tx_done_irq_out   // transmit-end request
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < 8) begin : g_adr_chk
        $error("ssc_top: ADDR_W below the 8 decoded address bits");
    end
    if (BAUD_DIV < 1 || BAUD_DIV > 4096) begin : g_div_chk
        $error("ssc_top: BAUD_DIV out of range");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic        ack_q;        // registered acknowledge
    logic [31:0] rdat_q;       // registered read data
    logic        acc;          // access completes this edge
    logic        wr_stat;      // accepted status write, low lane
    logic        rd_stat;      // accepted status read
    logic        wr_ctrl;      // accepted control write
    logic        wr_mode;      // accepted mode write
    logic [7:0]  ctrl_q;       // serial_control_flags
    logic [7:0]  mode_q;       // serial_mode_reg
    logic [7:0]  rxd_q;        // rx_data_reg
    logic        tx_done_q;       // tx_done
    logic        mpb_q;        // rx_multiproc_bit
    logic        mpbt_q;       // plain rw bit 0
    logic        tx_holding_empty;         // tx_holding_empty
    logic        rx_holding_full;         // rx_holding_full
    logic        overrun_flag;         // overrun_flag
    logic        framing_fault;          // framing_fault
    logic        parity_fault;          // parity_fault
    logic [7:0]  status;       // assembled serial_status_flags
    logic        tx_off_edge;  // tx_on written from 1 to 0
    logic        rx_ok;        // receive accepted by rx path
    logic        rx_ovr;       // completion while rx_holding_full is high
    logic        rx_ferr;      // async stop bit low
    logic        sync_mode;    // synchronous mode selected
    logic        sck_s1_q;     // pin sync stage one
    logic        sck_s2_q;     // pin sync stage two
    logic        sck_d_q;      // previous synced level
    logic [12:0] div_q;        // bit-rate divider
    logic        int_tick;     // internal clock edge
    logic        sck_int_q;    // internal bit-rate clock level
    ssc_pkg::ssc_pin_drv_t sck_drv; // pin drive pair

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // effects land on the edge that the master sees ack high
    assign acc     = wb_cyc_in && wb_stb_in && ack_q;
    assign wr_stat = acc && wb_we_in && wb_sel_in[0]
                     && (wb_adr_in[7:0] == ssc_pkg::OFF_STATUS);
    assign rd_stat = acc && !wb_we_in && (wb_adr_in[7:0] == ssc_pkg::OFF_STATUS);
    assign wr_ctrl = acc && wb_we_in && wb_sel_in[0]
                     && (wb_adr_in[7:0] == ssc_pkg::OFF_CONTROL);
    assign wr_mode = acc && wb_we_in && wb_sel_in[0]
                     && (wb_adr_in[7:0] == ssc_pkg::OFF_MODE);

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_in && wb_stb_in && !ack_q;
        end
    end

    // read data captured with the ack; unmapped reads give zero
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdat_q <= 32'h0000_0000;
        end else if (wb_cyc_in && wb_stb_in && !ack_q) begin
            case (wb_adr_in[7:0])
                ssc_pkg::OFF_STATUS:  rdat_q <= {24'h00_0000, status};
                ssc_pkg::OFF_CONTROL: rdat_q <= {24'h00_0000, ctrl_q};
                ssc_pkg::OFF_MODE:    rdat_q <= {24'h00_0000, mode_q};
                ssc_pkg::OFF_RXDATA:  rdat_q <= {24'h00_0000, rxd_q};
                default:              rdat_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // ------------------------------------------------------------
    // control and mode registers
    // ------------------------------------------------------------
    // ordering of select vs mode writes is up to software
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= ssc_pkg::RST_CONTROL;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= ssc_pkg::RST_MODE;
        end else if (wr_mode) begin
            mode_q <= wb_dat_in[7:0];
        end
    end

    assign sync_mode   = mode_q[ssc_pkg::BIT_SYNC];
    assign tx_on_out   = ctrl_q[ssc_pkg::BIT_TXON];
    assign rx_on_out   = ctrl_q[ssc_pkg::BIT_RXON];
    assign tx_off_edge = wr_ctrl && tx_on_out && !wb_dat_in[ssc_pkg::BIT_TXON];

    // ------------------------------------------------------------
    // receive event qualification
    // ------------------------------------------------------------
    // halted receiver ignores completions; rx off keeps flags as they are
    assign rx_halt_out = overrun_flag || framing_fault || parity_fault;
    assign tx_halt_out = sync_mode && rx_halt_out;
    assign rx_ok   = rx_evt_in.done && rx_on_out && !rx_halt_out;
    assign rx_ovr  = rx_ok && rx_holding_full;
    assign rx_ferr = rx_ok && !rx_holding_full && !sync_mode
                     && !rx_evt_in.stop_bit;
    // only the first stop bit reaches stop_bit; a second is never looked at

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    ssc_rc_flag #(.RST_VAL(ssc_pkg::RST_STATUS[ssc_pkg::BIT_TX_HOLDING_EMPTY])) u_tx_holding_empty (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .init_in     (standby_in),
        .set_in      (tx_load_in || tx_off_edge),
        .hw_clr_in   (1'b0),
        .rd_in       (rd_stat),
        .wr_in       (wr_stat),
        .wdat_in     (wb_dat_in[ssc_pkg::BIT_TX_HOLDING_EMPTY]),
        .flag_out    (tx_holding_empty)
    );

    ssc_rc_flag #(.RST_VAL(ssc_pkg::RST_STATUS[ssc_pkg::BIT_RX_HOLDING_FULL])) u_rx_holding_full (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .init_in     (standby_in),
        .set_in      (rx_ok && !rx_holding_full && !rx_ferr && !rx_evt_in.par_err),
        .hw_clr_in   (dma_rd_in),
        .rd_in       (rd_stat),
        .wr_in       (wr_stat),
        .wdat_in     (wb_dat_in[ssc_pkg::BIT_RX_HOLDING_FULL]),
        .flag_out    (rx_holding_full)
    );

    ssc_rc_flag #(.RST_VAL(ssc_pkg::RST_STATUS[ssc_pkg::BIT_OVERRUN_FLAG])) u_overrun_flag (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .init_in     (standby_in),
        .set_in      (rx_ovr),
        .hw_clr_in   (1'b0),
        .rd_in       (rd_stat),
        .wr_in       (wr_stat),
        .wdat_in     (wb_dat_in[ssc_pkg::BIT_OVERRUN_FLAG]),
        .flag_out    (overrun_flag)
    );

    ssc_rc_flag #(.RST_VAL(ssc_pkg::RST_STATUS[ssc_pkg::BIT_FER])) u_fer (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .init_in     (standby_in),
        .set_in      (rx_ferr),
        .hw_clr_in   (1'b0),
        .rd_in       (rd_stat),
        .wr_in       (wr_stat),
        .wdat_in     (wb_dat_in[ssc_pkg::BIT_FER]),
        .flag_out    (framing_fault)
    );

    ssc_rc_flag #(.RST_VAL(ssc_pkg::RST_STATUS[ssc_pkg::BIT_PER])) u_per (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .init_in     (standby_in),
        .set_in      (rx_ok && !rx_holding_full && rx_evt_in.par_err),
        .hw_clr_in   (1'b0),
        .rd_in       (rd_stat),
        .wr_in       (wr_stat),
        .wdat_in     (wb_dat_in[ssc_pkg::BIT_PER]),
        .flag_out    (parity_fault)
    );

    // tx_done: hardware only, writes are discarded
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_done_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_TX_DONE];
        end else if (standby_in) begin
            tx_done_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_TX_DONE];
        end else if (tx_off_edge || (tx_last_bit_in && tx_holding_empty)) begin
            tx_done_q <= 1'b1;
        end else if (tx_load_in || !tx_holding_empty) begin
            tx_done_q <= 1'b0;
        end
    end

    // received multiprocessor bit and character; read only to software
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mpb_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_MPB];
            rxd_q <= 8'h00;
        end else if (standby_in) begin
            mpb_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_MPB];
        end else if (rx_ok && !rx_holding_full) begin
            // framing or parity error still loads the character
            mpb_q <= rx_evt_in.rx_multiproc_bit;
            rxd_q <= rx_evt_in.data;
        end
    end
    assign rx_data_out = rxd_q;

    // bit 0 is plain storage
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mpbt_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_MPBT];
        end else if (standby_in) begin
            mpbt_q <= ssc_pkg::RST_STATUS[ssc_pkg::BIT_MPBT];
        end else if (wr_stat) begin
            mpbt_q <= wb_dat_in[ssc_pkg::BIT_MPBT];
        end
    end

    assign status = {tx_holding_empty, rx_holding_full, overrun_flag, framing_fault, parity_fault, tx_done_q, mpb_q, mpbt_q};

    // ------------------------------------------------------------
    // transmit-end request
    // ------------------------------------------------------------
    // drops with tx_holding_empty clear (which clears tx_done) or enable off
    assign tx_done_irq_out = tx_done_q && ctrl_q[ssc_pkg::BIT_TX_DONE_IRQ_EN];

    // ------------------------------------------------------------
    // clock source select and sck pin
    // ------------------------------------------------------------
    // two-flop sync; only the second stage feeds the edge finder
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_d_q  <= 1'b0;
        end else begin
            sck_s1_q <= sck_pin_in;
            sck_s2_q <= sck_s1_q;
            sck_d_q  <= sck_s2_q;
        end
    end

    // internal bit-rate clock, free running
    assign int_tick = (div_q == 13'(BAUD_DIV - 1));
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q     <= 13'h0000;
            sck_int_q <= 1'b0;
        end else if (int_tick) begin
            div_q     <= 13'h0000;
            sck_int_q <= !sck_int_q;
        end else begin
            div_q     <= div_q + 13'h0001;
        end
    end

    // pin role from select bits and mode
    always_comb begin
        sck_drv.out = sck_int_q;
        if (ctrl_q[ssc_pkg::BIT_CKH]) begin
            sck_drv.oe = 1'b0;
        end else if (sync_mode) begin
            sck_drv.oe = 1'b1;
        end else begin
            sck_drv.oe = ctrl_q[ssc_pkg::BIT_CKL];
        end
    end
    assign sck_pin_out    = sck_drv.out;
    assign sck_pin_oe_out = sck_drv.oe;
    assign ext_clk_sel_out = ctrl_q[ssc_pkg::BIT_CKH];
    // external rising edge (16x bit rate in async) or internal edge
    assign bit_clk_tick_out = ext_clk_sel_out ? (sck_s2_q && !sck_d_q)
                                              : (int_tick && !sck_int_q);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_read_tx_holding_empty_one;
        rd_stat && tx_holding_empty;
    endsequence
    sequence s_write_tx_holding_empty_zero;
        wr_stat && !wb_dat_in[ssc_pkg::BIT_TX_HOLDING_EMPTY] && !tx_load_in && !standby_in;
    endsequence

    irq_gate_a: assert property (wr_ctrl && !wb_dat_in[ssc_pkg::BIT_TX_DONE_IRQ_EN]
        |=> !tx_done_irq_out)
        else $error("irq not gated by enable");
    // no other access fits between two accesses two or three cycles apart
    irq_drop_a: assert property (s_read_tx_holding_empty_one ##[2:3] s_write_tx_holding_empty_zero
        |=> !tx_holding_empty ##1 !tx_done_irq_out)
        else $error("irq stays after tx_holding_empty clear");
    sck_role_a: assert property (sck_pin_oe_out == (!ctrl_q[ssc_pkg::BIT_CKH]
        && (sync_mode || ctrl_q[ssc_pkg::BIT_CKL])))
        else $error("sck drive does not match select");
    ext_clk_a: assert property (ctrl_q[ssc_pkg::BIT_CKH] |-> !sck_pin_oe_out
        && ext_clk_sel_out)
        else $error("external clock select drives pin");
    wr1_ignored_a: assert property (wr_stat && !standby_in && !rx_holding_full && !rx_ok
        |=> !rx_holding_full)
        else $error("write 1 set rx_holding_full");
    // two status writes in a row with no read between them cannot clear
    no_seen_a: assert property (wr_stat ##[2:3] (wr_stat && tx_holding_empty && !standby_in)
        |=> tx_holding_empty)
        else $error("tx_holding_empty cleared without read");
    standby_a: assert property (standby_in |=> status[7:1] == ssc_pkg::RST_STATUS[7:1]
        && mpbt_q == 1'b0)
        else $error("status not reloaded on standby");
    tx_holding_empty_set_a: assert property (tx_load_in && !standby_in |=> tx_holding_empty)
        else $error("tx_holding_empty not set on shift load");
    rx_holding_full_set_a: assert property (rx_ok && !rx_holding_full && !rx_ferr && !rx_evt_in.par_err
        && !standby_in |=> rx_holding_full && rxd_q == $past(rx_evt_in.data))
        else $error("clean receive not flagged");
    overrun_a: assert property (rx_ovr && !standby_in |=> overrun_flag
        && $stable(rxd_q) && rx_halt_out)
        else $error("overrun not flagged or data lost");
    fer_set_a: assert property (rx_ferr && !standby_in |=> framing_fault && !rx_holding_full
        && rxd_q == $past(rx_evt_in.data))
        else $error("framing error handling wrong");
    tx_done_set_a: assert property (tx_last_bit_in && tx_holding_empty && !standby_in
        |=> tx_done_q)
        else $error("tx_done not set at end");
endmodule // ssc_top
`default_nettype wire

/* testbench/ssc_far_end.sv */
// Purpose: far side model, external serial clock on the sck pin
// Assumes: clock runs only while a frame is active
// Notes: phase offset keeps pin edges off core edges
`timescale 1ns/10ps
`default_nettype none
module ssc_far_end (
    input  wire logic run_in,  // frame active
    output logic      sck_out  // level offered to the pin
);
    // 80 ns external clock, stands low between frames
    initial begin
        sck_out = 1'b0;
        #3;
        forever #40 sck_out = run_in ? ~sck_out : 1'b0;
    end
endmodule // ssc_far_end
`default_nettype wire

/* testbench/ssc_top_bench.sv */
// Purpose: self-checking bench for status flags and clock select
// Assumes: wishbone tasks wait on ack, no fixed latency
// Notes: BAUD_DIV shortened to 2
`timescale 1ns/10ps
`default_nettype none
module ssc_top_bench;
    localparam logic [7:0] st = ssc_pkg::OFF_STATUS, ct = ssc_pkg::OFF_CONTROL;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, sb = 0, ld = 0, lb = 0, dma = 0;
    logic run = 0, oe, po, far, tick, ext, rh, irq, ack, th, ton, ron, po_l = 0;
    logic [7:0] adr = 0, rd, rxd;
    logic [31:0] wd = 0, dout;
    ssc_pkg::ssc_rx_evt_t evt = '0;
    int error_cnt = 0, tests_run = 0, cyc_n = 0, ticks = 0, flips = 0;
    wire pin = oe ? po : far; // wire level from both parties
    ssc_top #(.ADDR_W(8), .BAUD_DIV(2)) ssc_top_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
        .wb_dat_in(wd), .wb_dat_out(dout), .wb_ack_out(ack), .standby_in(sb), .rx_evt_in(evt),
        .tx_load_in(ld), .tx_last_bit_in(lb), .dma_rd_in(dma), .sck_pin_in(pin),
        .sck_pin_out(po), .sck_pin_oe_out(oe), .bit_clk_tick_out(tick), .ext_clk_sel_out(ext),
        .rx_halt_out(rh), .tx_halt_out(th), .tx_on_out(ton), .rx_on_out(ron), .rx_data_out(rxd),
        .tx_done_irq_out(irq));
    ssc_far_end ssc_far_end_i (.run_in(run), .sck_out(far));
    always #4 clk = ~clk;
    // cycle ceiling and tick counting
    always @(posedge clk) begin
        cyc_n++;
        if (tick === 1'b1) ticks++;
        if (po !== po_l) flips++;
        po_l = po;
        if (cyc_n == 20000) begin error_cnt++; give_verdict(); end
    end
    task automatic chk(input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin error_cnt++; $display("wrong value %0t: %h not %h", $time, s, e); end
    endtask
    // classic single cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, d);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = dout[7:0]; cyc <= 0; stb <= 0; @(posedge clk);
    endtask
    // one-cycle pulse on {standby, load, last bit, dma}
    task automatic pulse(input logic [3:0] m);
        {sb, ld, lb, dma} <= m; @(posedge clk); {sb, ld, lb, dma} <= 4'h0; @(posedge clk);
    endtask
    task automatic rx(input logic [7:0] d, input logic stop);
        evt <= '{1'b1, stop, 1'b0, 1'b0, d}; @(posedge clk); evt.done <= 0; @(posedge clk);
    endtask
    task automatic t_reg;
        wb(0, st, 0); chk(rd, 8'h84);
        wb(0, 8'h40, 0); chk(rd, 0);
        wb(1, st, 8'hFE); wb(1, st, 0); wb(0, st, 0); chk(rd, 8'h84);
        wb(1, st, 0); wb(0, st, 0); chk(rd, 0);
    endtask
    task automatic t_tx;
        wb(1, ct, 8'h24); chk({6'h0, ton, ron}, 8'h02);
        pulse(4'h4); pulse(4'h2); chk({7'h0, irq}, 1);
        wb(1, ct, 8'h20); chk({7'h0, irq}, 0);
        wb(0, st, 0); wb(1, st, 0); wb(1, ct, 0); wb(0, st, 0); chk(rd, 8'h84);
    endtask
    task automatic t_rx;
        wb(1, ct, 8'h10); chk({6'h0, ton, ron}, 8'h01);
        rx(8'hA5, 1); wb(0, st, 0); chk(rd, 8'hC4);
        rx(8'h5A, 1); rx(8'h33, 1); chk(rxd, 8'hA5); chk({7'h0, rh}, 1);
        chk({7'h0, th}, 0); wb(1, ssc_pkg::OFF_MODE, 8'h80); chk({7'h0, th}, 1);
        wb(1, ssc_pkg::OFF_MODE, 0);
        pulse(4'h1); wb(1, ct, 0); wb(0, st, 0); chk(rd, 8'hA4);
        wb(1, ct, 8'h10); wb(1, st, 8'hDE); rx(8'h3C, 0); chk(rxd, 8'h3C);
        wb(0, st, 0); chk(rd, 8'h94); pulse(4'h8); wb(0, st, 0); chk(rd, 8'h84);
    endtask
    // every select value in both modes, select bits written before the mode
    task automatic t_clk;
        for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++) begin
            wb(1, ct, s[7:0]); wb(1, ssc_pkg::OFF_MODE, {m[0], 7'h0});
            chk({6'h0, ext, oe}, {6'h0, s[1], !s[1] && (s[0] || m[0])});
        end
        wb(1, ct, 8'h02); wb(1, ssc_pkg::OFF_MODE, 0); ticks = 0; run <= 1;
        repeat (100) @(posedge clk);
        run <= 0; chk({7'h0, ticks inside {[9:10]}}, 1);
        // internal clock on the pin: one tick per four cycles, a level change per two
        wb(1, ct, 8'h01); ticks = 0; flips = 0;
        repeat (40) @(posedge clk);
        chk({7'h0, ticks inside {[9:11]}}, 1); chk({7'h0, flips inside {[19:21]}}, 1);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1; t_reg(); t_tx(); t_rx(); t_clk(); give_verdict();
    end
endmodule // ssc_top_bench
`default_nettype wire
